/* ref_edge_unit.v */
// vertical reference edge selection and field id recovery
`timescale 1ns/10ps
`default_nettype none
module ref_edge_unit
(
    // clock and reset
    input  wire       clk_in,
    input  wire       resetn_in,
    // reference inputs
    input  wire       use_x_port_in,
    input  wire       ext_vertical_ref_in,
    input  wire       ext_horizontal_ref_in,
    input  wire       decoder_vertical_signal_in,
    input  wire       decoder_field_id_in,
    // settings
    input  wire       vertical_ref_edge_in,
    input  wire       vertical_ref_type_in,
    input  wire       field_id_source_invert_in,
    input  wire       field_detect_edge_in,
    // results
    output reg        vref_pulse_out,
    output reg        field_id_out
);
    reg  prev_vref;
    reg  x_field;
    wire vref;
    wire rise;
    wire fall;
    wire fd_hit;

    assign vref = use_x_port_in ? ext_vertical_ref_in
                                : decoder_vertical_signal_in;
    assign rise = vref & ~prev_vref;
    assign fall = ~vref & prev_vref;
    assign fd_hit = field_detect_edge_in ? rise : fall;  // [RULE17]

    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            prev_vref      <= 1'b0;
            x_field        <= 1'b0;
            vref_pulse_out <= 1'b0;
            field_id_out   <= 1'b0;
        end
        else
        begin
            prev_vref <= vref;
            // frame sync gives a pulse on either edge
            if (vertical_ref_type_in)
                vref_pulse_out <= rise | fall;  // [RULE14]
            else
                vref_pulse_out <= vertical_ref_edge_in ? fall : rise;  // [RULE13]
            if (fd_hit)
                x_field <= ext_horizontal_ref_in;  // [RULE15]
            field_id_out <= (use_x_port_in ? x_field : decoder_field_id_in)
                            ^ field_id_source_invert_in;  // [RULE16]
        end
    end
endmodule // ref_edge_unit
`default_nettype wire

/* scaler_cfg_map.vh */
// register map and field layout of the scaler task and input configuration
`ifndef SCALER_CFG_MAP_VH
`define SCALER_CFG_MAP_VH

// register indices; byte address is four times the index
`define TASK_CTL_A_IDX     8'h90
`define FMT_CFG_A_IDX      8'h91
`define REF_DEF_A_IDX      8'h92
`define TASK_CTL_B_IDX     8'hc0
`define FMT_CFG_B_IDX      8'hc1
`define REF_DEF_B_IDX      8'hc2
`define HANDLER_STAT_IDX   8'hbf
`define ADDR_LSB           2

// reset values of the writable registers
`define TASK_CTL_RST       8'h00
`define FMT_CFG_RST        8'h08
`define REF_DEF_RST        8'h00

// task handling control fields
`define TRIG_LO            0
`define TRIG_HI            1
`define REPEAT_BIT         2
`define SKIP_LO            3
`define SKIP_HI            5

// input format configuration fields
`define SAMPLING_BIT       0
`define CHROMA_LO          1
`define CHROMA_HI          2
`define REQ_EN_BIT         3
`define SRC_LO             4
`define SRC_HI             5
`define HOLD_FV_BIT        6
`define V_INVERT_BIT       7

// input reference definition fields
`define VREF_EDGE_BIT      4
`define VREF_TYPE_BIT      5
`define FID_INVERT_BIT     6
`define FD_EDGE_BIT        7

// trigger codes and source codes
`define TRIG_DONE          2'h0
`define TRIG_VSYNC         2'h1
`define TRIG_FID0          2'h2
`define TRIG_FID1          2'h3
`define SRC_DECODER        2'h0
`define SRC_X_YCBCR        2'h1
`define SRC_RAW_ANALOG     2'h2
`define SRC_X_RAW          2'h3

`endif

/* scaler_task_cfg.v */
// scaler task event handler and input configuration with ahb-lite registers
// Operation
// RULE1: two identical register sets, A and B
// RULE2: two-bit trigger: done, vsync, fid0, fid1
// RULE3: repeat bit runs active task once more
// RULE4: request mode only with external request enabled
// RULE5: request enable means continuous uninterruptible input
// RULE6: two-bit field selects scaler input source
// RULE7: software avoids raw analog composite source
// RULE8: hold bit freezes F and V until line start
// RULE9: v invert flips V bit and gate pin
// RULE10: lowest format bit picks 4:2:2 or 4:1:1
// RULE11: chroma every line, 2nd, 3rd or 4th
// RULE12: source sends dummy chroma when rate nonzero
// RULE13: vertical edge bit picks rising or falling
// RULE14: frame sync type pulses on both edges
// RULE15: x port field id sampled from href
// RULE16: field id invert bit inverts both ids
// RULE17: field detect edge: falling or rising
// RULE18: skip zero to seven fields before task
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "scaler_cfg_map.vh"
`default_nettype none
module scaler_task_cfg
(
    // clock and reset
    input  wire        clk_in,
    input  wire        resetn_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // video references and scaler status
    input  wire        ext_vertical_ref_in,
    input  wire        ext_horizontal_ref_in,
    input  wire        decoder_vertical_signal_in,
    input  wire        decoder_field_id_in,
    input  wire        external_request_enable_in,
    input  wire        scaler_ready_in,
    input  wire        task_done_in,
    input  wire        out_line_start_in,
    input  wire        proc_f_in,
    input  wire        proc_v_in,
    // configuration to the scaler
    output reg         active_set_out,
    output reg         task_start_out,
    output reg  [1:0]  scaler_source_out,
    output reg         continuous_stream_out,
    output reg         source_request_out,
    output reg         sampling_scheme_out,
    output reg  [1:0]  chroma_rate_out,
    output reg         vref_pulse_out,
    output reg         field_id_out,
    // sav/eav bits and vertical gate
    output reg         sav_f_out,
    output reg         sav_v_out,
    output reg         gp_vertical_out_pin_out
);
    localparam [2:0] ST_SKIP = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    reg  [7:0]  task_ctl [0:1];
    reg  [7:0]  fmt_cfg  [0:1];
    reg  [7:0]  ref_def  [0:1];
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [2:0]  skip_left;
    reg  [2:0]  next_skip_left;
    reg         next_set;
    reg         next_start;
    reg         repeated;
    reg         next_repeated;
    reg         wr_pend;
    reg  [7:0]  wr_idx;
    reg  [7:0]  rd_val;
    reg         vref_late;
    wire [7:0]  a_idx;
    wire        a_valid;
    wire        set_sel;
    wire [7:0]  tc;
    wire [7:0]  fc;
    wire [7:0]  rd;
    wire        vref_pulse;
    wire        field_id;
    wire        trig_hit;
    wire        use_x;

    // which register of a set an index names: 1 task, 2 format, 3 refs
    function [1:0] reg_kind;
        input [7:0] idx;
        begin
            case (idx)
                `TASK_CTL_A_IDX, `TASK_CTL_B_IDX: reg_kind = 2'h1;
                `FMT_CFG_A_IDX,  `FMT_CFG_B_IDX:  reg_kind = 2'h2;
                `REF_DEF_A_IDX,  `REF_DEF_B_IDX:  reg_kind = 2'h3;
                default:                          reg_kind = 2'h0;
            endcase
        end
    endfunction

    // set B lives in the c0 block of indices
    function is_set_b;
        input [7:0] idx;
        begin
            is_set_b = idx[6];
        end
    endfunction

    assign a_idx   = haddr_in[`ADDR_LSB+7:`ADDR_LSB];
    assign a_valid = hsel_in & htrans_in[1] & hready_in;

    // register sets A and B, identical layout
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_set
            always @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    task_ctl[g] <= `TASK_CTL_RST;
                    fmt_cfg[g]  <= `FMT_CFG_RST;
                    ref_def[g]  <= `REF_DEF_RST;
                end
                else if (wr_pend && is_set_b(wr_idx) == g)  // [RULE1]
                begin
                    case (reg_kind(wr_idx))
                        2'h1:    task_ctl[g] <= hwdata_in[7:0];
                        2'h2:    fmt_cfg[g]  <= hwdata_in[7:0];
                        2'h3:    ref_def[g]  <= hwdata_in[7:0];
                        default: task_ctl[g] <= task_ctl[g];
                    endcase
                end
            end
        end
    endgenerate

    // read mux; a write in its data phase is forwarded to a following read
    always @*
    begin
        rd_val = 8'h00;
        case (reg_kind(a_idx))
            2'h1: rd_val = task_ctl[is_set_b(a_idx)];
            2'h2: rd_val = fmt_cfg[is_set_b(a_idx)];
            2'h3: rd_val = ref_def[is_set_b(a_idx)];
            default:
            begin
                if (a_idx == `HANDLER_STAT_IDX)
                    rd_val = {2'h0, skip_left, state[1], repeated,
                              active_set_out};
            end
        endcase
        if (wr_pend && wr_idx == a_idx && reg_kind(a_idx) != 2'h0)
            rd_val = hwdata_in[7:0];
    end

    // ahb-lite slave: zero wait states, always okay
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_pend       <= 1'b0;
            wr_idx        <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end
        else
        begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            wr_pend       <= a_valid & hwrite_in;
            wr_idx        <= a_idx;
            if (a_valid && !hwrite_in)
                hrdata_out <= {24'h00_0000, rd_val};
        end
    end

    // settings of the set that owns the active task
    assign set_sel = active_set_out;
    assign tc      = task_ctl[set_sel];
    assign fc      = fmt_cfg[set_sel];
    assign rd      = ref_def[set_sel];
    assign use_x   = fc[`SRC_LO];  // [RULE6]

    ref_edge_unit u_ref
    (
        .clk_in                     (clk_in),
        .resetn_in                  (resetn_in),
        .use_x_port_in              (use_x),
        .ext_vertical_ref_in        (ext_vertical_ref_in),
        .ext_horizontal_ref_in      (ext_horizontal_ref_in),
        .decoder_vertical_signal_in (decoder_vertical_signal_in),
        .decoder_field_id_in        (decoder_field_id_in),
        .vertical_ref_edge_in       (rd[`VREF_EDGE_BIT]),
        .vertical_ref_type_in       (rd[`VREF_TYPE_BIT]),
        .field_id_source_invert_in  (rd[`FID_INVERT_BIT]),
        .field_detect_edge_in       (rd[`FD_EDGE_BIT]),
        .vref_pulse_out             (vref_pulse),
        .field_id_out               (field_id)
    );

    // field id settles one cycle after the pulse of the edge that sampled
    // it; the field triggers wait for it instead of using the old field
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            vref_late <= 1'b0;
        else
            vref_late <= vref_pulse;
    end

    // trigger decode of the active set
    assign trig_hit =
        (tc[`TRIG_HI:`TRIG_LO] == `TRIG_DONE)  ? 1'b1 :
        (tc[`TRIG_HI:`TRIG_LO] == `TRIG_VSYNC) ? vref_pulse :
        (tc[`TRIG_HI:`TRIG_LO] == `TRIG_FID0)  ? (vref_late & ~field_id) :
                                                 (vref_late & field_id);
                                                 // [RULE2]

    // event handler
    always @*
    begin
        next_state     = state;
        next_skip_left = skip_left;
        next_set       = active_set_out;
        next_repeated  = repeated;
        next_start     = 1'b0;
        case (state)
            ST_SKIP:
            begin
                if (skip_left == 3'h0)
                begin
                    next_start = 1'b1;  // [RULE18]
                    next_state = ST_RUN;
                end
                else if (vref_pulse)
                    next_skip_left = skip_left - 3'h1;  // [RULE18]
            end
            ST_RUN:
            begin
                if (task_done_in)
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (trig_hit)
                begin
                    // repeat once, then the other set takes over
                    if (tc[`REPEAT_BIT] && !repeated)
                        next_repeated = 1'b1;  // [RULE3]
                    else
                    begin
                        next_repeated = 1'b0;
                        next_set      = ~active_set_out;  // [RULE3]
                    end
                    next_skip_left = next_set ?
                        task_ctl[1][`SKIP_HI:`SKIP_LO] :
                        task_ctl[0][`SKIP_HI:`SKIP_LO];  // [RULE18]
                    next_state = ST_SKIP;
                end
            end
            default:
            begin
                next_state = ST_SKIP;
            end
        endcase
    end

    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state          <= ST_WAIT;
            skip_left      <= 3'h0;
            repeated       <= 1'b0;
            active_set_out <= 1'b0;
            task_start_out <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            skip_left      <= next_skip_left;
            repeated       <= next_repeated;
            active_set_out <= next_set;
            task_start_out <= next_start;
        end
    end

    // input configuration and sav/eav bit handling
    always @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scaler_source_out       <= `SRC_DECODER;
            continuous_stream_out   <= 1'b1;
            source_request_out      <= 1'b1;
            sampling_scheme_out     <= 1'b0;
            chroma_rate_out         <= 2'h0;
            vref_pulse_out          <= 1'b0;
            field_id_out            <= 1'b0;
            sav_f_out               <= 1'b0;
            sav_v_out               <= 1'b0;
            gp_vertical_out_pin_out <= 1'b0;
        end
        else
        begin
            scaler_source_out   <= fc[`SRC_HI:`SRC_LO];  // [RULE6]
            sampling_scheme_out <= fc[`SAMPLING_BIT];  // [RULE10]
            chroma_rate_out     <= fc[`CHROMA_HI:`CHROMA_LO];  // [RULE11]
            vref_pulse_out      <= vref_pulse;
            field_id_out        <= field_id;
            // a decoder source never waits, whatever the bit says
            if (fc[`REQ_EN_BIT] || !external_request_enable_in ||
                fc[`SRC_HI:`SRC_LO] == `SRC_DECODER)
            begin
                continuous_stream_out <= 1'b1;  // [RULE5]
                source_request_out    <= 1'b1;  // [RULE5]
            end
            else
            begin
                continuous_stream_out <= 1'b0;
                source_request_out    <= scaler_ready_in;  // [RULE4]
            end
            gp_vertical_out_pin_out <= proc_v_in ^ fc[`V_INVERT_BIT];  // [RULE9]
            if (!fc[`HOLD_FV_BIT] || out_line_start_in)  // [RULE8]
            begin
                sav_f_out <= proc_f_in;
                sav_v_out <= proc_v_in ^ fc[`V_INVERT_BIT];  // [RULE9]
            end
        end
    end
endmodule // scaler_task_cfg
`default_nettype wire

/* scaler_task_cfg_checker.sv */
// concurrent checks on the ports of the scaler task configuration block
`timescale 1ns/10ps
`default_nettype none
`include "scaler_cfg_map.vh"
module scaler_task_cfg_checker
(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        resetn_in,
    // register bus
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // scaler side
    input wire logic        scaler_ready_in,
    input wire logic        external_request_enable_in,
    input wire logic        task_start_out,
    input wire logic        continuous_stream_out,
    input wire logic        source_request_out,
    input wire logic        vref_pulse_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    wire [7:0] idx = haddr_in[9:2];
    wire       mapped = idx inside {`TASK_CTL_A_IDX, `FMT_CFG_A_IDX,
        `REF_DEF_A_IDX, `TASK_CTL_B_IDX, `FMT_CFG_B_IDX, `REF_DEF_B_IDX,
        `HANDLER_STAT_IDX};

    sequence rd_unmapped;
        hsel_in && htrans_in[1] && !hwrite_in && hready_in && !mapped;
    endsequence
    sequence start_pulse;
        task_start_out ##1 !task_start_out;
    endsequence

    AST_HREADY: assert property ($past(resetn_in) |-> hreadyout_out)
        else $error("wait state inserted on the register bus");
    AST_HRESP: assert property (hresp_out == 1'b0)
        else $error("error response on the register bus");
    AST_HRDATA_HI: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_UNMAPPED_RD: assert property (rd_unmapped |=> hrdata_out == 32'h0)
        else $error("unmapped read returned data");
    AST_TASK_PULSE: assert property (task_start_out |-> start_pulse)
        else $error("task start longer than one cycle");
    AST_VREF_PULSE: assert property (vref_pulse_out |=> !vref_pulse_out)
        else $error("vertical reference pulse too long");
    AST_REQ_CONT: assert property (continuous_stream_out |-> source_request_out)
        else $error("continuous input not requested");
    AST_REQ_FOLLOW: assert property (!continuous_stream_out |->
        source_request_out == $past(scaler_ready_in))
        else $error("request does not follow scaler ready");
    AST_CONT_EXT: assert property (!external_request_enable_in |=>
        continuous_stream_out)
        else $error("request mode without external request enable");
endmodule // scaler_task_cfg_checker

bind scaler_task_cfg scaler_task_cfg_checker i_scaler_task_cfg_checker (
    .clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .scaler_ready_in,
    .external_request_enable_in, .task_start_out, .continuous_stream_out,
    .source_request_out, .vref_pulse_out);
`default_nettype wire

/* scaler_task_cfg_tb.sv */
// self-checking testbench of the scaler task and input configuration block
`timescale 1ns/10ps
`default_nettype none
`include "scaler_cfg_map.vh"
module scaler_task_cfg_tb;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        hsel, hwrite, done, ready, ext_req, line_start;
    logic        proc_f, proc_v, dec_v, dec_fid, go, fld;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata;
    wire  [31:0] hrdata;
    wire         hready, hresp, aset, tstart, cont, sreq, samp, vp, fid;
    wire         sav_f, sav_v, gpv, xv, xh;
    wire  [1:0]  src, crate;
    int          errors, cmp_count, starts, vps, cyc, vtime;
    logic [7:0]  ids [6] = '{`TASK_CTL_A_IDX, `FMT_CFG_A_IDX, `REF_DEF_A_IDX,
                             `TASK_CTL_B_IDX, `FMT_CFG_B_IDX, `REF_DEF_B_IDX};
    logic [7:0]  rvals [3] = '{`TASK_CTL_RST, `FMT_CFG_RST, `REF_DEF_RST};

    scaler_task_cfg i_scaler_task_cfg (
        .clk_in, .resetn_in, .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp),
        .ext_vertical_ref_in(xv), .ext_horizontal_ref_in(xh),
        .decoder_vertical_signal_in(dec_v), .decoder_field_id_in(dec_fid),
        .external_request_enable_in(ext_req), .scaler_ready_in(ready),
        .task_done_in(done), .out_line_start_in(line_start),
        .proc_f_in(proc_f), .proc_v_in(proc_v), .active_set_out(aset),
        .task_start_out(tstart), .scaler_source_out(src),
        .continuous_stream_out(cont), .source_request_out(sreq),
        .sampling_scheme_out(samp), .chroma_rate_out(crate),
        .vref_pulse_out(vp), .field_id_out(fid), .sav_f_out(sav_f),
        .sav_v_out(sav_v), .gp_vertical_out_pin_out(gpv));
    xport_source_model i_xport_source_model (.clk_in, .go_in(go),
        .field_in(fld), .ext_vertical_ref_out(xv),
        .ext_horizontal_ref_out(xh));

    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        ready <= 1'($urandom);
        cyc <= cyc + 1;
        if (tstart === 1'b1)
            starts <= starts + 1;
        if (vp === 1'b1)
        begin
            vps <= vps + 1;
            vtime <= cyc;
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            errors++;
            print_verdict();
        end
    endtask
    // one single word transfer; data taken at the edge ending data phase
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask
    // same value into set a and set b keeps the active set irrelevant
    task automatic wr2(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] t;
        bus(1'b1, idx, d, t);
        bus(1'b1, idx + 8'h30, d, t);
    endtask
    task automatic frame(input logic f);
        fld <= f;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(16);
    endtask
    task automatic finish_task;
        done <= 1'b1;
        tick(1);
        done <= 1'b0;
        tick(6);
    endtask

    initial
    begin
        logic [31:0] rd;
        logic [7:0]  f, wv [6];
        logic        a, b;
        int          n, c;
        {hsel, hwrite, done, ready, ext_req, line_start} = 6'h0;
        {proc_f, proc_v, dec_v, dec_fid, go, fld, htrans} = 8'h0;
        {haddr, hwdata} = 64'h0;
        void'($urandom(43));
        tick(10);
        resetn_in <= 1'b1;
        tick(2);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, ids[i], 8'h0, rd);
            chk("reset value", rvals[i % 3], rd);
            wv[i] = 8'($urandom);
            if (i % 3 == 1)
            begin
                wv[i][4] = wv[i][4] | wv[i][5];
                wv[i][2:1] = wv[i][4] ? wv[i][2:1] : 2'h0;
            end
        end
        for (int i = 0; i < 6; i++)
            bus(1'b1, ids[i], wv[i], rd);
        bus(1'b1, 8'h93, 8'hff, rd);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, ids[i], 8'h0, rd);
            chk("register", wv[i], rd);
        end
        bus(1'b0, 8'h93, 8'h0, rd);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        for (int i = 0; i < 16; i++)
        begin
            f = 8'($urandom);
            f[5:4] = i[1:0] | {1'b0, i[1]};
            f[2:1] = f[4] ? i[3:2] : 2'h0;
            {ext_req, proc_f, proc_v, dec_v, dec_fid} <= 5'($urandom);
            wr2(`FMT_CFG_A_IDX, f);
            tick(2);
            chk("source", f[5:4], src);
            chk("chroma rate", f[2:1], crate);
            chk("sampling", f[0], samp);
            chk("continuous", f[3] | (f[5:4] == 2'h0) | !ext_req, cont);
            line_start <= 1'b1;
            tick(1);
            line_start <= 1'b0;
            tick(2);
            chk("sav f", proc_f, sav_f);
            chk("sav v", proc_v ^ f[7], sav_v);
            {proc_f, proc_v} <= ~{proc_f, proc_v};
            tick(3);
            chk("sav f held", f[6] ? !proc_f : proc_f, sav_f);
            chk("v gate", proc_v ^ f[7], gpv);
        end
        $display("test input format done");
        wr2(`FMT_CFG_A_IDX, 8'h18);
        for (int i = 0; i < 16; i++)
        begin
            wr2(`REF_DEF_A_IDX, {i[3:0], 4'h0});
            b = 1'($urandom);
            n = vps;
            c = cyc;
            frame(b);
            chk("field id", (i[3] ? b : !b) ^ i[2], fid);
            chk("vref count", i[1] ? 2 : 1, vps - n);
            if (!i[1])
                chk("vref edge", i[0], (vtime - c) > 9);
        end
        $display("test references done");
        wr2(`REF_DEF_A_IDX, 8'h80);
        for (int t = 0; t < 4; t++)
        begin
            wr2(`TASK_CTL_A_IDX, {6'h0, t[1:0]});
            frame(!t[0]);
            a = aset;
            n = starts;
            finish_task();
            chk("early start", t == 0, starts - n);
            if (t != 0)
                frame(t[0]);
            chk("start", 1, starts - n);
            chk("set switch", !a, aset);
        end
        wr2(`TASK_CTL_A_IDX, 8'h04);
        a = aset;
        finish_task();
        chk("repeat", a, aset);
        finish_task();
        chk("after repeat", !a, aset);
        wr2(`TASK_CTL_A_IDX, 8'h10);
        n = starts;
        finish_task();
        frame(1'b0);
        chk("skip one", 0, starts - n);
        frame(1'b0);
        chk("skip two", 1, starts - n);
        $display("test task handler done");
        print_verdict();
    end
    initial
    begin
        #400us;
        errors++;
        print_verdict();
    end
endmodule // scaler_task_cfg_tb
`default_nettype wire

/* xport_source_model.sv */
// behavioural expansion port source driving the vertical and horizontal refs
`timescale 1ns/10ps
`default_nettype none
module xport_source_model
(
    // clock and frame request
    input  wire logic clk_in,
    input  wire logic go_in,
    input  wire logic field_in,
    // reference lines
    output var  logic ext_vertical_ref_out,
    output var  logic ext_horizontal_ref_out
);
    initial
    begin
        ext_vertical_ref_out = 1'b0;
        ext_horizontal_ref_out = 1'b0;
    end
    // href differs at the two vref edges so the chosen edge shows
    always @(posedge go_in)
    begin
        ext_horizontal_ref_out <= field_in;
        repeat (3) @(posedge clk_in);
        ext_vertical_ref_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        ext_horizontal_ref_out <= ~field_in;
        repeat (3) @(posedge clk_in);
        ext_vertical_ref_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        // hold time over: line no longer shows the last value
        ext_horizontal_ref_out <= field_in;
    end
endmodule // xport_source_model
`default_nettype wire
